// [core/slfs_pkg.sv]
// slfs_pkg: constants, register map and state encoding for the serial link framing/sync block.
// assumes a 20 MHz system clock that samples the serial bit clock and data of the transceiver.
//
// Overview of operation
// R1: each byte travels as one 10-bit character; every ten received bits form one character.
// R2: flag any received 10-bit pattern that breaks run-length or disparity rules.
// R3: while reframing is allowed, test for a comma at every bit position, every bit.
// R4: on a comma match, restart character timing at the comma; keep that alignment afterwards.
// R5: the comma is seven bits 0011111 or its complement 1100000.
// R6: a comma only occurs inside K28.5, so a match marks a K28.5 boundary.
// R7: a separate sync state machine decides when realignment on commas is allowed.
// R8: the sync machine has five states: one sync-lost and four locked error levels.
// R9: one shared 4-bit counter counts K28.5 when lost, good characters when locked; it stays at zero in locked_no_errors.
// R10: only six special characters are used; control travels in the data stream.
// R11: the link runs at a fixed 200 Mbit/s, one character every ten bit times.
// R12: after reset the machine is sync-lost with reframing enabled.
// R13: leave sync-lost only after fifteen K28.5 with no violation in between.
// R14: once locked, drop reframe enable; K28.5 is still decoded but does not realign.
// R15: violation moves one state deeper, fifteen good back one, deepest error loses sync.
// R16: machine and counter step once per received character, and reset to sync-lost; a cleared enable bit forces sync-lost on any clock.
// R17: the shared counter clears on every state change.

package slfs_pkg;

	// bus geometry
	localparam int          ADDR_W          = 8;
	localparam logic [7:0]  OFS_CTRL        = 8'h00;
	localparam logic [7:0]  OFS_STATUS      = 8'h04;
	localparam logic [7:0]  OFS_IRQ_STATUS  = 8'h08;
	localparam logic [7:0]  OFS_IRQ_MASK    = 8'h0c;
	localparam logic [7:0]  OFS_VIOL_COUNT  = 8'h10;
	localparam logic [7:0]  OFS_LAST_CHAR   = 8'h14;
	localparam logic [1:0]  RESP_OKAY       = 2'h0;
	localparam logic [1:0]  RESP_SLVERR     = 2'h2;

	// reset values
	localparam logic        CTRL_EN_RST     = 1'b1;
	localparam logic [2:0]  IRQ_MASK_RST    = 3'h0;

	// interrupt bit positions
	localparam int          IRQ_LOST_BIT    = 0;
	localparam int          IRQ_ACQ_BIT     = 1;
	localparam int          IRQ_VIOL_BIT    = 2;

	// line coding
	localparam int          LINE_RATE_MBPS  = 200;
	localparam logic [3:0]  CHAR_BITS       = 4'ha;
	localparam logic [3:0]  COMMA_BITS      = 4'h7;
	localparam logic [6:0]  COMMA_POS       = 7'h1f;
	localparam logic [6:0]  COMMA_NEG       = 7'h60;
	localparam logic [9:0]  K285_NEG_RD     = 10'h0fa;
	localparam logic [9:0]  K285_POS_RD     = 10'h305;
	localparam logic [2:0]  RUN_MAX         = 3'h5;
	localparam logic [3:0]  ONES_MIN        = 4'h4;
	localparam logic [3:0]  ONES_MID        = 4'h5;
	localparam logic [3:0]  ONES_MAX        = 4'h6;

	// sync counting
	localparam logic [3:0]  SYNC_THRESH     = 4'hf;

	// one sync-lost state and four locked error levels
	typedef enum logic [4:0] { // R8
		sync_lost_state     = 5'b00001,
		locked_no_errors    = 5'b00010,
		locked_one_error    = 5'b00100,
		locked_two_errors   = 5'b01000,
		locked_three_errors = 5'b10000
	} slfs_state_t;

endpackage

// [core/slfs_top.sv]
// slfs_top: bit sampling, comma framing, code checking, sync machine and AXI4-Lite registers.
// assumes the bit clock and data arrive from another domain and are much slower than clk.
//
// The AXI4-Lite slave port and the address map were decided locally.
`timescale 1ns/1ps
`default_nettype none

module slfs_top #(
	parameter int VIOL_W = 16
) (
	input  wire logic                      clk,
	input  wire logic                      reset_n,
	input  wire logic                      rx_bit_clk,
	input  wire logic                      rx_bit_data,
	input  wire logic [slfs_pkg::ADDR_W-1:0] s_axi_awaddr,
	input  wire logic                      s_axi_awvalid,
	output logic                           s_axi_awready,
	input  wire logic [31:0]               s_axi_wdata,
	input  wire logic [3:0]                s_axi_wstrb,
	input  wire logic                      s_axi_wvalid,
	output logic                           s_axi_wready,
	output logic [1:0]                     s_axi_bresp,
	output logic                           s_axi_bvalid,
	input  wire logic                      s_axi_bready,
	input  wire logic [slfs_pkg::ADDR_W-1:0] s_axi_araddr,
	input  wire logic                      s_axi_arvalid,
	output logic                           s_axi_arready,
	output logic [31:0]                    s_axi_rdata,
	output logic [1:0]                     s_axi_rresp,
	output logic                           s_axi_rvalid,
	input  wire logic                      s_axi_rready,
	output logic [9:0]                     rx_char,
	output logic                           rx_char_strobe,
	output logic                           code_violation_flag,
	output logic                           k285_flag,
	output logic                           reframe_enable,
	output logic                           sync_locked,
	output logic                           irq
);
	import slfs_pkg::*;

	initial begin
		if (VIOL_W < 1 || VIOL_W > 32) begin
			$error("VIOL_W must be 1 to 32");
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// state

	typedef struct packed {
		logic               ck1, ck2, ck3, ck_f;
		logic               dt1, dt2, dt3, dt_f;
		logic [9:0]         sreg;
		logic [3:0]         bitcnt;
		logic [2:0]         run_len;
		logic               last_bit;
		logic               run_err;
		logic               rd;
		logic               reframe;
		logic               locked;
		slfs_state_t        state;
		logic [3:0]         cnt;
		logic [9:0]         char_q;
		logic               char_stb;
		logic               viol;
		logic               k285;
		logic [VIOL_W-1:0]  viol_total;
		logic               ctrl_en;
		logic [2:0]         irq_stat;
		logic [2:0]         irq_mask;
		logic               irq;
		logic               awready, wready, aw_got, w_got, bvalid;
		logic [1:0]         bresp;
		logic [7:0]         awaddr;
		logic [31:0]        wdata;
		logic               wstrb0;
		logic               arready, rvalid;
		logic [1:0]         rresp;
		logic [31:0]        rdata;
	} slfs_regs_t;

	slfs_regs_t s_q;
	slfs_regs_t s_d;

	logic        bit_edge;
	logic        bit_val;
	logic [9:0]  shifted;
	logic        comma;
	logic        char_done;
	logic        run_err_now;
	logic [3:0]  ones;
	logic        viol_now;
	logic        k285_now;
	logic [2:0]  irq_set;
	logic [2:0]  irq_clr;
	logic [31:0] rd_word;
	logic        rd_ok;

	////////////////////////////////////////////////////////////////////////////////
	// next-state logic

	always_comb begin
		s_d         = s_q;
		s_d.char_stb = 1'b0;
		irq_set     = 3'h0;
		irq_clr     = 3'h0;
		comma       = 1'b0;
		char_done   = 1'b0;
		run_err_now = s_q.run_err;
		ones        = 4'h0;
		viol_now    = 1'b0;
		k285_now    = 1'b0;
		rd_word     = 32'h0;
		rd_ok       = 1'b1;

		// three-stage sampling; a change counts once stages two and three agree
		s_d.ck1 = rx_bit_clk;
		s_d.ck2 = s_q.ck1;
		s_d.ck3 = s_q.ck2;
		s_d.dt1 = rx_bit_data;
		s_d.dt2 = s_q.dt1;
		s_d.dt3 = s_q.dt2;
		if (s_q.ck2 == s_q.ck3) begin
			s_d.ck_f = s_q.ck3;
		end
		if (s_q.dt2 == s_q.dt3) begin
			s_d.dt_f = s_q.dt3;
		end
		bit_edge = (s_q.ck2 == s_q.ck3) && s_q.ck3 && !s_q.ck_f;
		bit_val  = (s_q.dt2 == s_q.dt3) ? s_q.dt3 : s_q.dt_f;
		shifted  = {s_q.sreg[8:0], bit_val};

		// bit-level framing and run-length tracking
		if (bit_edge) begin
			s_d.sreg     = shifted;
			s_d.last_bit = bit_val;
			if (bit_val == s_q.last_bit) begin
				if (s_q.run_len == RUN_MAX) begin
					run_err_now = 1'b1; // R2
				end else begin
					s_d.run_len = s_q.run_len + 3'h1;
				end
			end else begin
				s_d.run_len = 3'h1;
			end
			s_d.run_err = run_err_now;
			// comma search runs on every bit while reframing is allowed
			comma = s_q.reframe && (shifted[6:0] == COMMA_POS || shifted[6:0] == COMMA_NEG); // R3 R5
			if (comma) begin
				s_d.bitcnt = COMMA_BITS; // R4 R6
			end else if (s_q.bitcnt == CHAR_BITS - 4'h1) begin
				s_d.bitcnt = 4'h0; // R1 R11
				char_done  = 1'b1;
			end else begin
				s_d.bitcnt = s_q.bitcnt + 4'h1;
			end
		end

		// character check: weight and running disparity, simplified to whole characters
		if (char_done) begin
			ones     = 4'($countones(shifted));
			viol_now = run_err_now || ones < ONES_MIN || ones > ONES_MAX
				|| (ones == ONES_MAX && s_q.rd) || (ones == ONES_MIN && !s_q.rd); // R2
			if (ones == ONES_MAX) begin
				s_d.rd = 1'b1;
			end else if (ones == ONES_MIN) begin
				s_d.rd = 1'b0;
			end
			k285_now     = (shifted == K285_NEG_RD) || (shifted == K285_POS_RD); // R6 R10
			s_d.run_err  = 1'b0;
			s_d.char_q   = shifted;
			s_d.char_stb = 1'b1;
			s_d.viol     = viol_now;
			s_d.k285     = k285_now;
			if (viol_now) begin
				irq_set[IRQ_VIOL_BIT] = 1'b1;
				if (s_q.viol_total != {VIOL_W{1'b1}}) begin
					s_d.viol_total = s_q.viol_total + {{(VIOL_W-1){1'b0}}, 1'b1};
				end
			end
		end

		// sync machine, one step per character, forced to sync-lost on any clock while disabled; it alone gates reframing
		if (char_done) begin // R7 R16
			unique case (s_q.state)
				sync_lost_state: begin
					if (viol_now) begin
						s_d.cnt = 4'h0; // R13
					end else if (k285_now) begin // R9
						if (s_q.cnt == SYNC_THRESH - 4'h1) begin
							s_d.state = locked_no_errors; // R13
						end else begin
							s_d.cnt = s_q.cnt + 4'h1;
						end
					end
				end
				locked_no_errors: begin
					if (viol_now) begin
						s_d.state = locked_one_error; // R15
					end
				end
				locked_one_error, locked_two_errors, locked_three_errors: begin
					if (viol_now) begin
						s_d.state = (s_q.state == locked_three_errors) ? sync_lost_state
							: slfs_state_t'({s_q.state[3:0], 1'b0}); // R15
					end else if (s_q.cnt == SYNC_THRESH - 4'h1) begin
						s_d.state = slfs_state_t'({1'b0, s_q.state[4:1]}); // R15
					end else begin
						s_d.cnt = s_q.cnt + 4'h1; // R9
					end
				end
			endcase
		end
		if (!s_q.ctrl_en) begin
			s_d.state = sync_lost_state;
		end
		if (s_d.state != s_q.state) begin
			s_d.cnt = 4'h0; // R17
			if (s_d.state == sync_lost_state) begin
				irq_set[IRQ_LOST_BIT] = 1'b1;
			end
			if (s_q.state == sync_lost_state) begin
				irq_set[IRQ_ACQ_BIT] = 1'b1;
			end
		end
		s_d.reframe = (s_d.state == sync_lost_state); // R12 R14
		s_d.locked  = (s_d.state != sync_lost_state); // own flop keeps the output glitch-free

		// write channel: address and data taken in either order, answered once both are in
		if (s_axi_awvalid && s_q.awready) begin
			s_d.awaddr  = s_axi_awaddr;
			s_d.aw_got  = 1'b1;
			s_d.awready = 1'b0;
		end
		if (s_axi_wvalid && s_q.wready) begin
			s_d.wdata  = s_axi_wdata;
			s_d.wstrb0 = s_axi_wstrb[0];
			s_d.w_got  = 1'b1;
			s_d.wready = 1'b0;
		end
		if (s_q.aw_got && s_q.w_got) begin
			s_d.aw_got = 1'b0;
			s_d.w_got  = 1'b0;
			s_d.bvalid = 1'b1;
			s_d.bresp  = RESP_OKAY;
			unique case (s_q.awaddr)
				OFS_CTRL: begin
					if (s_q.wstrb0) begin
						s_d.ctrl_en = s_q.wdata[0];
					end
				end
				OFS_IRQ_MASK: begin
					if (s_q.wstrb0) begin
						s_d.irq_mask = s_q.wdata[2:0];
					end
				end
				OFS_STATUS, OFS_IRQ_STATUS, OFS_VIOL_COUNT, OFS_LAST_CHAR: begin
					s_d.bresp = RESP_OKAY; // read-only, write ignored
				end
				default: begin
					s_d.bresp = RESP_SLVERR;
				end
			endcase
		end
		if (s_q.bvalid && s_axi_bready) begin
			s_d.bvalid  = 1'b0;
			s_d.awready = 1'b1;
			s_d.wready  = 1'b1;
		end

		// read channel; reading the interrupt status clears it, a same-cycle event survives
		unique case (s_axi_araddr)
			OFS_CTRL:       rd_word = {31'h0, s_q.ctrl_en};
			OFS_STATUS:     rd_word = {19'h0, s_q.rd, s_q.cnt, 2'h0, s_q.reframe, s_q.state};
			OFS_IRQ_STATUS: rd_word = {29'h0, s_q.irq_stat};
			OFS_IRQ_MASK:   rd_word = {29'h0, s_q.irq_mask};
			OFS_VIOL_COUNT: rd_word = 32'(s_q.viol_total);
			OFS_LAST_CHAR:  rd_word = {20'h0, s_q.k285, s_q.viol, s_q.char_q};
			default:        rd_ok   = 1'b0;
		endcase
		if (s_axi_arvalid && s_q.arready) begin
			s_d.arready = 1'b0;
			s_d.rvalid  = 1'b1;
			s_d.rdata   = rd_word;
			s_d.rresp   = rd_ok ? RESP_OKAY : RESP_SLVERR;
			if (s_axi_araddr == OFS_IRQ_STATUS) begin
				irq_clr = s_q.irq_stat;
			end
		end
		if (s_q.rvalid && s_axi_rready) begin
			s_d.rvalid  = 1'b0;
			s_d.arready = 1'b1;
		end

		// sticky interrupt bits, set wins over clear
		s_d.irq_stat = (s_q.irq_stat & ~irq_clr) | irq_set;
		s_d.irq      = |(s_d.irq_stat & s_d.irq_mask);
	end

	////////////////////////////////////////////////////////////////////////////////
	// registers

	// reset puts the machine in sync-lost with reframing on
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			s_q          <= '0;
			s_q.state    <= sync_lost_state; // R12 R16
			s_q.reframe  <= 1'b1; // R12
			s_q.ctrl_en  <= CTRL_EN_RST;
			s_q.irq_mask <= IRQ_MASK_RST;
			s_q.awready  <= 1'b1;
			s_q.wready   <= 1'b1;
			s_q.arready  <= 1'b1;
		end else begin
			s_q <= s_d;
		end
	end

	// outputs straight from flops
	assign s_axi_awready       = s_q.awready;
	assign s_axi_wready        = s_q.wready;
	assign s_axi_bresp         = s_q.bresp;
	assign s_axi_bvalid        = s_q.bvalid;
	assign s_axi_arready       = s_q.arready;
	assign s_axi_rdata         = s_q.rdata;
	assign s_axi_rresp         = s_q.rresp;
	assign s_axi_rvalid        = s_q.rvalid;
	assign rx_char             = s_q.char_q;
	assign rx_char_strobe      = s_q.char_stb;
	assign code_violation_flag = s_q.viol;
	assign k285_flag           = s_q.k285;
	assign reframe_enable      = s_q.reframe;
	assign sync_locked         = s_q.locked;
	assign irq                 = s_q.irq;

	////////////////////////////////////////////////////////////////////////////////
	// assertions

	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);

	property p_onehot;
		$onehot(s_q.state);
	endproperty
	a_onehot: assert property (p_onehot) else $error("sync state not one-hot"); // R8

	property p_reframe_lost;
		s_q.reframe == (s_q.state == sync_lost_state);
	endproperty
	a_reframe_lost: assert property (p_reframe_lost) else $error("reframe wrong for state"); // R14

	property p_acquire;
		(s_q.state == sync_lost_state && s_d.state == locked_no_errors)
			|-> (s_q.cnt == 4'he && k285_now && !viol_now);
	endproperty
	a_acquire: assert property (p_acquire) else $error("lock before fifteen clean K28.5"); // R13

	property p_cnt_clear;
		(s_q.state != $past(s_q.state)) |-> s_q.cnt == 4'h0;
	endproperty
	a_cnt_clear: assert property (p_cnt_clear) else $error("counter not cleared"); // R17

	property p_step_per_char;
		(s_q.state != $past(s_q.state)) |-> (s_q.char_stb || !$past(s_q.ctrl_en));
	endproperty
	a_step_per_char: assert property (p_step_per_char) else $error("state moved off char"); // R16

	property p_deep_loss;
		(s_q.state == locked_three_errors && char_done && viol_now)
			|=> s_q.state == sync_lost_state && s_q.reframe;
	endproperty
	a_deep_loss: assert property (p_deep_loss) else $error("deepest error kept lock"); // R15

	property p_first_err;
		(s_q.state == locked_no_errors && char_done && viol_now && s_q.ctrl_en)
			|=> s_q.state == locked_one_error;
	endproperty
	a_first_err: assert property (p_first_err) else $error("violation did not advance"); // R15

	property p_comma_align;
		(bit_edge && s_q.reframe && (shifted[6:0] == COMMA_POS || shifted[6:0] == COMMA_NEG))
			|=> s_q.bitcnt == COMMA_BITS;
	endproperty
	a_comma_align: assert property (p_comma_align) else $error("comma did not realign"); // R4

	property p_no_realign;
		(bit_edge && !s_q.reframe && s_q.bitcnt != CHAR_BITS - 4'h1)
			|=> s_q.bitcnt == $past(s_q.bitcnt) + 4'h1;
	endproperty
	a_no_realign: assert property (p_no_realign) else $error("realigned while locked"); // R14

	property p_weight;
		(s_q.char_stb && ($countones(s_q.char_q) < 4 || $countones(s_q.char_q) > 6))
			|-> s_q.viol;
	endproperty
	a_weight: assert property (p_weight) else $error("bad weight not flagged"); // R2

	property p_k285;
		(s_q.char_stb && (s_q.char_q == K285_NEG_RD || s_q.char_q == K285_POS_RD)) |-> s_q.k285;
	endproperty
	a_k285: assert property (p_k285) else $error("K28.5 not flagged"); // R6

	property p_irq;
		s_q.irq == |(s_q.irq_stat & s_q.irq_mask);
	endproperty
	a_irq: assert property (p_irq) else $error("irq disagrees with status and mask");

	c_acquire: cover property (s_q.state == sync_lost_state ##1 s_q.state == locked_no_errors);
	c_recover: cover property (s_q.state == locked_one_error ##1 s_q.state == locked_no_errors);
	c_loss: cover property (s_q.state == locked_three_errors ##1 s_q.state == sync_lost_state);
	c_read: cover property (s_q.rvalid && s_axi_rready);

endmodule

`default_nettype wire

// [testbench/slfs_link_model.sv]
// slfs_link_model: receiver-side serial transceiver stand-in, shifts characters onto the link.
// assumes the bench calls send_bits; the bit clock stands still between characters.
`timescale 1ns/1ps
`default_nettype none

module slfs_link_model (
	output logic rx_bit_clk,
	output logic rx_bit_data
);

	realtime last_rise;

	// idle link: clock parked low
	initial begin
		rx_bit_clk  = 1'b0;
		rx_bit_data = 1'b0;
		last_rise   = 0.0;
	end

	//////////////////////////////////////////////////////////////////////////
	// n bits of v, first bit on the wire is v[n-1]; 400 ns bit period
	task automatic send_bits(input logic [9:0] v, input int n);
		int k;
		begin
			#13; // keeps the link phase apart from clk
			for (k = n - 1; k >= 0; k--) begin
				rx_bit_data <= v[k];
				#200;
				rx_bit_clk <= 1'b1;
				last_rise  = $realtime;
				#200;
				rx_bit_clk <= 1'b0;
			end
			// data is released after the hold time: show the opposite level
			rx_bit_data <= ~rx_bit_data;
		end
	endtask

endmodule

`default_nettype wire

// [testbench/slfs_top_tb.sv]
// slfs_top_tb: drives the link model and an AXI4-Lite master, checks framing and sync.
// assumes slfs_pkg and slfs_top are compiled first; clk is 20 MHz.
`timescale 1ns/1ps
`default_nettype none

module slfs_top_tb;
	import slfs_pkg::*;

	logic        clk, reset_n, rx_bit_clk, rx_bit_data;
	logic [7:0]  awaddr, araddr;
	logic [31:0] wdata, rdata;
	logic [3:0]  wstrb;
	logic [1:0]  bresp, rresp;
	logic        awvalid, awready, wvalid, wready, bvalid, bready;
	logic        arvalid, arready, rvalid, rready;
	logic [9:0]  rx_char;
	logic        rx_char_strobe, code_violation_flag, k285_flag;
	logic        reframe_enable, sync_locked, irq;
	logic [31:0] rd_q;
	logic [1:0]  rr_q;
	logic [1:0]  br_q;
	int          err_total, tests_run, i;
	realtime     strobe_time;

	slfs_top i_slfs_top (.clk(clk), .reset_n(reset_n), .rx_bit_clk(rx_bit_clk),
		.rx_bit_data(rx_bit_data), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.rx_char(rx_char), .rx_char_strobe(rx_char_strobe),
		.code_violation_flag(code_violation_flag), .k285_flag(k285_flag),
		.reframe_enable(reframe_enable), .sync_locked(sync_locked), .irq(irq));

	slfs_link_model i_slfs_link_model (.rx_bit_clk(rx_bit_clk), .rx_bit_data(rx_bit_data));

	// 50 ns clock
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	// time of the latest character strobe, so a stale one is never taken for a new one
	always @(posedge clk) begin
		if (rx_char_strobe === 1'b1)
			strobe_time <= $realtime;
	end

	//////////////////////////////////////////////////////////////////////////
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			err_total++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic hung();
		err_total++;
		$display("unexpected at %0t: wait ran out", $time);
		give_verdict();
	endtask

	// both address and data offered together, each dropped once taken
	task automatic axi_write(input logic [7:0] a, input logic [31:0] d);
		int n;
		begin
			@(posedge clk);
			awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
			for (n = 0; n < 50; n++) begin
				@(posedge clk);
				if (awvalid && awready) awvalid <= 1'b0;
				if (wvalid && wready) wvalid <= 1'b0;
				if (bvalid === 1'b1) begin
					br_q = bresp;
					break;
				end
			end
			bready <= 1'b0;
			if (n == 50) hung();
		end
	endtask

	task automatic axi_read(input logic [7:0] a);
		int n;
		begin
			@(posedge clk);
			araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
			for (n = 0; n < 50; n++) begin
				@(posedge clk);
				if (arvalid && arready) arvalid <= 1'b0;
				if (rvalid === 1'b1) begin
					rd_q = rdata;
					rr_q = rresp;
					break;
				end
			end
			rready <= 1'b0;
			if (n == 50) hung();
		end
	endtask

	// running disparity bit 12 is left out of the comparison
	task automatic check_status(input logic [11:0] exp);
		axi_read(OFS_STATUS);
		check({20'h0, rd_q[11:0]}, {20'h0, exp});
	endtask

	task automatic wait_irq(input logic exp);
		int n;
		for (n = 0; n < 8 && irq !== exp; n++) @(posedge clk);
		check({31'h0, irq}, {31'h0, exp});
	endtask

	task automatic send_char(input logic [9:0] c);
		int n;
		begin
			i_slfs_link_model.send_bits(c, 10);
			for (n = 0; n < 40 && strobe_time <= i_slfs_link_model.last_rise; n++)
				@(posedge clk);
			if (n == 40) hung();
			@(negedge clk);
		end
	endtask

	// nv violating characters, then ng clean neutral characters, then the state word
	task automatic send_run(input int nv, input int ng, input logic [11:0] exp);
		int k;
		begin
			for (k = 0; k < nv; k++) begin
				send_char(10'h111);
				check({31'h0, code_violation_flag}, 32'h1);
			end
			for (k = 0; k < ng; k++) begin
				send_char(10'h155);
				check({31'h0, code_violation_flag}, 32'h0);
			end
			check_status(exp);
		end
	endtask

	task automatic reset_and_check();
		reset_n <= 1'b0;
		repeat (8) @(posedge clk);
		reset_n <= 1'b1;
		@(negedge clk);
		check({30'h0, reframe_enable, sync_locked}, 32'h2);
		check({31'h0, irq}, 32'h0);
		check_status(12'h021);
		axi_read(OFS_IRQ_MASK);
		check(rd_q, {29'h0, IRQ_MASK_RST});
		axi_read(OFS_CTRL);
		check(rd_q, {31'h0, CTRL_EN_RST});
		axi_read(OFS_VIOL_COUNT);
		check(rd_q, 32'h0);
	endtask

	//////////////////////////////////////////////////////////////////////////
	// main sequence
	initial begin
		err_total = 0;
		tests_run = 0;
		strobe_time = 0.0;
		reset_n <= 1'b0;
		awaddr <= 8'h00; araddr <= 8'h00; wdata <= 32'h0; wstrb <= 4'hf;
		awvalid <= 1'b0; wvalid <= 1'b0; bready <= 1'b0; arvalid <= 1'b0; rready <= 1'b0;
		reset_and_check();
		axi_read(8'h20);
		check({30'h0, rr_q}, {30'h0, RESP_SLVERR});
		check(rd_q, 32'h0);
		// five stray bits put the first comma off the reset framing; the partial
		// character they form with the first five K28.5 bits is checked but neutral, so the first K28.5 sees the negative disparity left by reset
		i_slfs_link_model.send_bits(10'h012, 5);
		for (i = 0; i < 15; i++) begin
			send_char(i[0] ? K285_POS_RD : K285_NEG_RD);
			check({22'h0, rx_char}, {22'h0, i[0] ? K285_POS_RD : K285_NEG_RD});
			check({31'h0, k285_flag}, 32'h1);
			if (i == 13) begin
				check({31'h0, sync_locked}, 32'h0);
				check_status(12'he21);
			end
		end
		check({30'h0, reframe_enable, sync_locked}, 32'h1);
		check_status(12'h002);
		// acquired event is held while masked, shows once unmasked, clears on read
		check({31'h0, irq}, 32'h0);
		axi_write(OFS_IRQ_MASK, 32'h2);
		check({30'h0, br_q}, {30'h0, RESP_OKAY});
		wait_irq(1'b1);
		axi_read(OFS_IRQ_STATUS);
		check(rd_q & 32'h2, 32'h2);
		wait_irq(1'b0);
		// error ladder: recovery needs fifteen clean characters in a row
		send_run(1, 14, 12'he04);
		send_run(1, 0, 12'h008);
		send_run(0, 15, 12'h004);
		send_run(1, 0, 12'h008);
		send_run(1, 0, 12'h010);
		send_run(1, 0, 12'h021);
		check({30'h0, reframe_enable, sync_locked}, 32'h2);
		axi_read(OFS_VIOL_COUNT);
		check(rd_q, 32'h5);
		// link disable reads back and is answered okay
		axi_write(OFS_CTRL, 32'h0);
		check({30'h0, br_q}, {30'h0, RESP_OKAY});
		axi_read(OFS_CTRL);
		check(rd_q, 32'h0);
		check({30'h0, reframe_enable, sync_locked}, 32'h2);
		// a reset in mid-run returns everything to sync-lost
		reset_and_check();
		give_verdict();
	end

	// cuts a hang short
	initial begin
		repeat (100000) @(posedge clk);
		hung();
	end

endmodule

`default_nettype wire
